// [design/rss_params.svh]
// What this block does
// - Eight segments, indexed 0 to 7, each with its own full set of settings.
// - Active segment adds its signed 30-bit step to the accumulator each tick until its duration count runs out.
// - Fastlock bit set turns on fastlock and slip reduction during the segment.
// - Half-rate bit set makes each tick last two clocks instead of one.
// - Duration counts ticks directly, 1 means one tick, up to 65536 ticks.
// - Segment marker field drives marker outputs, bit 0 and bit 1 each.
// - Clear bit set forces the accumulator to zero when that segment starts.
// - Advance selector picks duration end or event one, two or three.
// - A finished segment hands over to its programmed successor index.
// - Accumulator is clamped between signed 33-bit lower and upper limits.
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
`define RSS_SEG_COUNT 8
`define RSS_IDX_W 3
`define RSS_STEP_W 30
`define RSS_DUR_W 16
`define RSS_CNT_W 17
`define RSS_ACC_W 33
`define RSS_ADDR_W 12
`define RSS_OFS_CTRL 12'h000
`define RSS_OFS_STATUS 12'h004
`define RSS_OFS_LOW_LO 12'h008
`define RSS_OFS_LOW_HI 12'h00c
`define RSS_OFS_HIGH_LO 12'h010
`define RSS_OFS_HIGH_HI 12'h014
`define RSS_OFS_ACC_LO 12'h018
`define RSS_OFS_ACC_HI 12'h01c
`define RSS_SEG_PAGE 4'h1
`define RSS_WORD_STEP 2'h0
`define RSS_WORD_DUR 2'h1
`define RSS_WORD_FLAGS 2'h2
`define RSS_FB_SPEEDUP 0
`define RSS_FB_HALF 1
`define RSS_FB_MARK_LO 2
`define RSS_FB_MARK_HI 3
`define RSS_FB_CLEAR 4
`define RSS_FB_ADV_LO 5
`define RSS_FB_ADV_HI 6
`define RSS_FB_NEXT_LO 7
`define RSS_FB_NEXT_HI 9
`define RSS_LOW_RESET 33'h000000000
`define RSS_HIGH_RESET 33'h0ffffffff
`define RSS_RESP_OKAY 2'h0
`define RSS_RESP_SLVERR 2'h2
`endif

// [design/rss_pkg.sv]
`include "rss_params.svh"
package rss_pkg;
  // Advance event choices, in selector code order.
  typedef enum logic [1:0] {
    RSS_ADV_COUNT,
    RSS_ADV_EVENT_ONE,
    RSS_ADV_EVENT_TWO,
    RSS_ADV_EVENT_THREE
  } rss_adv_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    RSS_IDLE,
    RSS_LOAD,
    RSS_RUN
  } rss_state_t;

  // Settings of one segment.
  typedef struct packed {
    logic [`RSS_STEP_W-1:0] segment_step_value;
    logic [`RSS_DUR_W-1:0] segment_duration;
    logic segment_speedup_lock_enable;
    logic segment_half_rate_enable;
    logic [1:0] segment_marker_bits;
    logic segment_accumulator_clear;
    rss_adv_t segment_advance_select;
    logic [`RSS_IDX_W-1:0] segment_successor_index;
  } rss_seg_t;

  // Applies AXI byte strobes to a stored word.
  function automatic logic [31:0] rss_merge(input logic [31:0] old_word,
                                            input logic [31:0] new_word,
                                            input logic [3:0] strb);
    logic [31:0] result;
    result = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        result[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return result;
  endfunction : rss_merge
endpackage : rss_pkg

// [design/rss_seg_if.sv]
`timescale 1ns/10ps
`include "rss_params.svh"
interface rss_seg_if;
  import rss_pkg::*;
  logic wr_en;
  logic [`RSS_IDX_W-1:0] wr_seg;
  logic [1:0] wr_word;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [`RSS_IDX_W-1:0] rd_seg;
  logic [1:0] rd_word;
  logic [31:0] rd_data;
  logic [`RSS_IDX_W-1:0] cur_seg;
  rss_seg_t cur;
  modport bank (input wr_en, wr_seg, wr_word, wr_data, wr_strb, rd_seg,
                rd_word, cur_seg, output rd_data, cur);
  modport user (output wr_en, wr_seg, wr_word, wr_data, wr_strb, rd_seg,
                rd_word, cur_seg, input rd_data, cur);
endinterface : rss_seg_if

// [design/rss_seg_bank.sv]
`timescale 1ns/10ps
`include "rss_params.svh"
module rss_seg_bank (
  input wire logic aclk,
  input wire logic aresetn,
  rss_seg_if.bank seg
);
  import rss_pkg::*;

  rss_seg_t entry [`RSS_SEG_COUNT];

  // Packs one entry into its three software words.
  function automatic logic [31:0] word_of(input rss_seg_t e,
                                          input logic [1:0] w);
    logic [31:0] r;
    r = 32'h00000000;
    case (w)
      `RSS_WORD_STEP: r[`RSS_STEP_W-1:0] = e.segment_step_value;
      `RSS_WORD_DUR: r[`RSS_DUR_W-1:0] = e.segment_duration;
      `RSS_WORD_FLAGS:
      begin
        r[`RSS_FB_SPEEDUP] = e.segment_speedup_lock_enable;
        r[`RSS_FB_HALF] = e.segment_half_rate_enable;
        r[`RSS_FB_MARK_HI:`RSS_FB_MARK_LO] = e.segment_marker_bits;
        r[`RSS_FB_CLEAR] = e.segment_accumulator_clear;
        r[`RSS_FB_ADV_HI:`RSS_FB_ADV_LO] = e.segment_advance_select;
        r[`RSS_FB_NEXT_HI:`RSS_FB_NEXT_LO] = e.segment_successor_index;
      end
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction : word_of

  // Each segment keeps its own copy of every setting, cleared at reset.
  for (genvar i = 0; i < `RSS_SEG_COUNT; i++)
  begin : g_entry
    logic [31:0] merged;
    assign merged = rss_merge(word_of(entry[i], seg.wr_word), seg.wr_data,
                              seg.wr_strb);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        entry[i] <= '0;
      end
      else if (seg.wr_en && seg.wr_seg == `RSS_IDX_W'(i))
      begin
        case (seg.wr_word)
          `RSS_WORD_STEP:
            entry[i].segment_step_value <= merged[`RSS_STEP_W-1:0];
          `RSS_WORD_DUR:
            entry[i].segment_duration <= merged[`RSS_DUR_W-1:0];
          `RSS_WORD_FLAGS:
          begin
            entry[i].segment_speedup_lock_enable <= merged[`RSS_FB_SPEEDUP];
            entry[i].segment_half_rate_enable <= merged[`RSS_FB_HALF];
            entry[i].segment_marker_bits <=
              merged[`RSS_FB_MARK_HI:`RSS_FB_MARK_LO];
            entry[i].segment_accumulator_clear <= merged[`RSS_FB_CLEAR];
            entry[i].segment_advance_select <=
              rss_adv_t'(merged[`RSS_FB_ADV_HI:`RSS_FB_ADV_LO]);
            entry[i].segment_successor_index <=
              merged[`RSS_FB_NEXT_HI:`RSS_FB_NEXT_LO];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Software read word and the settings of the running segment.
  assign seg.rd_data = word_of(entry[seg.rd_seg], seg.rd_word);
  assign seg.cur = entry[seg.cur_seg];
endmodule : rss_seg_bank

// [design/rss_sequencer.sv]
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "rss_params.svh"
module rss_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`RSS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RSS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_source_one,
  input wire logic event_source_two,
  input wire logic event_source_three,
  output logic marker_out_zero,
  output logic marker_out_one,
  output logic fastlock_enable,
  output logic slip_reduce_enable,
  output logic [`RSS_ACC_W-1:0] ramp_value,
  output logic [`RSS_IDX_W-1:0] active_segment,
  output logic ramp_running
);
  import rss_pkg::*;

  rss_seg_if seg ();

  rss_seg_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .seg(seg)
  );

  logic ramp_enable;
  logic ramp_enable_d;
  logic [`RSS_ACC_W-1:0] limit_low;
  logic [`RSS_ACC_W-1:0] limit_high;
  logic aw_hold;
  logic w_hold;
  logic ar_hold;
  logic [`RSS_ADDR_W-1:0] aw_addr;
  logic [`RSS_ADDR_W-1:0] ar_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic [2:0] event_pulse;
  rss_state_t state;
  logic [`RSS_CNT_W-1:0] count;
  logic half_phase;
  logic tick;
  logic advance;
  logic signed [`RSS_ACC_W:0] sum;
  logic signed [`RSS_ACC_W:0] low_ext;
  logic signed [`RSS_ACC_W:0] high_ext;
  logic [`RSS_ACC_W-1:0] next_ramp_value;
  logic [31:0] global_rd;
  logic global_hit_w;
  logic global_hit_r;
  logic seg_hit_w;
  logic seg_hit_r;

  // Address decode for the segment page and the global words.
  assign seg_hit_w = aw_addr[`RSS_ADDR_W-1:8] == `RSS_SEG_PAGE &&
                     aw_addr[7] == 1'b0 && aw_addr[3:2] != 2'h3;
  assign seg_hit_r = ar_addr[`RSS_ADDR_W-1:8] == `RSS_SEG_PAGE &&
                     ar_addr[7] == 1'b0 && ar_addr[3:2] != 2'h3;
  assign global_hit_w = aw_addr <= `RSS_OFS_ACC_HI;
  assign global_hit_r = ar_addr <= `RSS_OFS_ACC_HI;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign rd_go = ar_hold && !s_axi_rvalid;

  // Segment bank write and read ports.
  assign seg.wr_en = wr_go && seg_hit_w;
  assign seg.wr_seg = aw_addr[6:4];
  assign seg.wr_word = aw_addr[3:2];
  assign seg.wr_data = w_data;
  assign seg.wr_strb = w_strb;
  assign seg.rd_seg = ar_addr[6:4];
  assign seg.rd_word = ar_addr[3:2];
  assign seg.cur_seg = active_segment;

  // Write address and data channels are taken in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_go)
      begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_go)
      begin
        w_hold <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response follows both halves; unmapped writes answer SLVERR.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (seg_hit_w || global_hit_w) ? `RSS_RESP_OKAY :
                     `RSS_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Global control words; limits hold their reset values until written.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ramp_enable <= 1'b0;
      limit_low <= `RSS_LOW_RESET;
      limit_high <= `RSS_HIGH_RESET;
    end
    else if (wr_go)
    begin
      case (aw_addr)
        `RSS_OFS_CTRL:
          if (w_strb[0]) ramp_enable <= w_data[0];
        `RSS_OFS_LOW_LO:
          limit_low[31:0] <= rss_merge(limit_low[31:0], w_data, w_strb);
        `RSS_OFS_LOW_HI:
          if (w_strb[0]) limit_low[32] <= w_data[0];
        `RSS_OFS_HIGH_LO:
          limit_high[31:0] <= rss_merge(limit_high[31:0], w_data, w_strb);
        `RSS_OFS_HIGH_HI:
          if (w_strb[0]) limit_high[32] <= w_data[0];
        default:
        begin
        end
      endcase
    end
  end

  // Read mux for the global words, status shows the sequencer's own state.
  always_comb
  begin
    global_rd = 32'h00000000;
    case (ar_addr)
      `RSS_OFS_CTRL: global_rd[0] = ramp_enable;
      `RSS_OFS_STATUS: global_rd[6:0] = {marker_out_one, marker_out_zero,
                                         active_segment, 1'b0, ramp_running};
      `RSS_OFS_LOW_LO: global_rd = limit_low[31:0];
      `RSS_OFS_LOW_HI: global_rd[0] = limit_low[32];
      `RSS_OFS_HIGH_LO: global_rd = limit_high[31:0];
      `RSS_OFS_HIGH_HI: global_rd[0] = limit_high[32];
      `RSS_OFS_ACC_LO: global_rd = ramp_value[31:0];
      `RSS_OFS_ACC_HI: global_rd[0] = ramp_value[32];
      default: global_rd = 32'h00000000;
    endcase
  end

  // Read channel: one read at a time, data two cycles after the address handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_hold <= 1'b0;
      ar_addr <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RSS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_hold <= 1'b1;
        ar_addr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      else if (rd_go)
      begin
        ar_hold <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= seg_hit_r ? seg.rd_data :
                       (global_hit_r ? global_rd : 32'h00000000);
        s_axi_rresp <= (seg_hit_r || global_hit_r) ? `RSS_RESP_OKAY :
                       `RSS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Event pins pass two flip-flops; a third stage finds the rising edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_c <= 3'h0;
    end
    else
    begin
      sync_a <= {sync_a[1:0], event_source_one};
      sync_b <= {sync_b[1:0], event_source_two};
      sync_c <= {sync_c[1:0], event_source_three};
    end
  end
  assign event_pulse = {sync_c[1] & ~sync_c[2], sync_b[1] & ~sync_b[2],
                        sync_a[1] & ~sync_a[2]};

  // A tick is every clock, or every second clock at half rate.
  assign tick = state == RSS_RUN &&
                (!seg.cur.segment_half_rate_enable || half_phase);

  // Selected event ends the segment: count end or one of three events.
  always_comb
  begin
    advance = 1'b0;
    if (state == RSS_RUN)
    begin
      case (seg.cur.segment_advance_select)
        RSS_ADV_COUNT: advance = tick && count == `RSS_CNT_W'(1);
        RSS_ADV_EVENT_ONE: advance = event_pulse[0];
        RSS_ADV_EVENT_TWO: advance = event_pulse[1];
        RSS_ADV_EVENT_THREE: advance = event_pulse[2];
        default: advance = 1'b0;
      endcase
    end
  end

  // Next accumulator value, clamped to the signed limits.
  assign sum = $signed({ramp_value[`RSS_ACC_W-1], ramp_value}) +
               $signed({{(`RSS_ACC_W+1-`RSS_STEP_W){
                 seg.cur.segment_step_value[`RSS_STEP_W-1]}},
                 seg.cur.segment_step_value});
  assign low_ext = $signed({limit_low[`RSS_ACC_W-1], limit_low});
  assign high_ext = $signed({limit_high[`RSS_ACC_W-1], limit_high});
  always_comb
  begin
    next_ramp_value = sum[`RSS_ACC_W-1:0];
    if (sum > high_ext)
    begin
      next_ramp_value = limit_high;
    end
    else if (sum < low_ext)
    begin
      next_ramp_value = limit_low;
    end
  end

  // Sequencer state, segment index, tick counter and half-rate phase.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= RSS_IDLE;
      ramp_enable_d <= 1'b0;
      active_segment <= '0;
      count <= '0;
      half_phase <= 1'b0;
    end
    else
    begin
      ramp_enable_d <= ramp_enable;
      case (state)
        RSS_IDLE:
          if (ramp_enable && !ramp_enable_d)
          begin
            active_segment <= '0;
            state <= RSS_LOAD;
          end
        RSS_LOAD:
        begin
          // A zero duration stands for the longest segment.
          count <= {seg.cur.segment_duration == '0,
                    seg.cur.segment_duration};
          half_phase <= 1'b0;
          state <= RSS_RUN;
        end
        RSS_RUN:
        begin
          half_phase <= seg.cur.segment_half_rate_enable && !half_phase;
          if (tick && count != '0)
          begin
            count <= count - `RSS_CNT_W'(1);
          end
          if (advance)
          begin
            active_segment <= seg.cur.segment_successor_index;
            state <= RSS_LOAD;
          end
        end
        default: state <= RSS_IDLE;
      endcase
      if (!ramp_enable)
      begin
        state <= RSS_IDLE;
      end
    end
  end

  // Accumulator: cleared at segment start on request, stepped per tick while the count is nonzero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ramp_value <= '0;
    end
    else if (state == RSS_LOAD && seg.cur.segment_accumulator_clear)
    begin
      ramp_value <= '0;
    end
    else if (tick && count != '0)
    begin
      ramp_value <= next_ramp_value;
    end
  end

  // Segment outputs follow the running segment and clear when idle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == RSS_IDLE)
    begin
      marker_out_zero <= 1'b0;
      marker_out_one <= 1'b0;
      fastlock_enable <= 1'b0;
      slip_reduce_enable <= 1'b0;
      ramp_running <= 1'b0;
    end
    else
    begin
      marker_out_zero <= seg.cur.segment_marker_bits[0];
      marker_out_one <= seg.cur.segment_marker_bits[1];
      fastlock_enable <= seg.cur.segment_speedup_lock_enable;
      slip_reduce_enable <= seg.cur.segment_speedup_lock_enable;
      ramp_running <= 1'b1;
    end
  end
endmodule : rss_sequencer

// [test/rss_sequencer_properties.sv]
`timescale 1ns/10ps
`include "rss_params.svh"
module rss_seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic marker_out_zero,
  input wire logic marker_out_one,
  input wire logic fastlock_enable,
  input wire logic slip_reduce_enable,
  input wire logic [`RSS_ACC_W-1:0] ramp_value,
  input wire logic [`RSS_IDX_W-1:0] active_segment,
  input wire logic ramp_running
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Ramp side: lock outputs, markers and the accumulator follow the state.
  a_speedup_pair: assert property (
    fastlock_enable == slip_reduce_enable)
    else $error("fastlock and slip outputs differ");
  a_idle_no_lock: assert property (
    !ramp_running && !$past(ramp_running) |-> !fastlock_enable)
    else $error("fastlock on while idle");
  a_idle_no_mark: assert property (
    !ramp_running && !$past(ramp_running) |->
      !marker_out_zero && !marker_out_one)
    else $error("marker on while idle");
  a_acc_frozen_idle: assert property (
    $changed(ramp_value) |-> ramp_running)
    else $error("accumulator moved while idle");
  a_load_no_tick: assert property (
    $changed(active_segment) && ramp_running |=>
      $stable(ramp_value) || ramp_value == '0)
    else $error("accumulator stepped in a load cycle");
  a_start_seg_zero: assert property (
    $rose(ramp_running) |-> active_segment == 3'h0)
    else $error("run did not start at segment zero");

  // Register bus: channel turn-around follows the hand-over timing.
  a_write_wait: assert property (
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels free before response");
  a_resp_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response did not retire");
  a_read_turn: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
    else $error("read data not on time");
  a_read_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response did not retire");

  // Main scenarios reached.
  c_start: cover property ($rose(ramp_running));
  c_chain: cover property ($changed(active_segment) && ramp_running);
  c_lock_mark: cover property (fastlock_enable && marker_out_zero);
endmodule : rss_seq_checker

bind rss_sequencer rss_seq_checker i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .marker_out_zero(marker_out_zero),
  .marker_out_one(marker_out_one), .fastlock_enable(fastlock_enable),
  .slip_reduce_enable(slip_reduce_enable), .ramp_value(ramp_value),
  .active_segment(active_segment), .ramp_running(ramp_running));

// [test/rss_trig_model.sv]
`timescale 1ns/10ps
`include "rss_params.svh"
module rss_trig_model (
  input wire logic aclk,
  input wire logic [2:0] fire,
  input wire logic [`RSS_ACC_W-1:0] ramp_value,
  output logic event_source_one,
  output logic event_source_two,
  output logic event_source_three
);
  logic [2:0] pulse = 3'h0;
  logic [`RSS_ACC_W-1:0] frac_word;

  // Each request gives a pulse off the clock grid, four clocks wide.
  for (genvar i = 0; i < 3; i++)
  begin : g_src
    always @(posedge fire[i])
    begin
      #2;
      pulse[i] = 1'b1;
      #20;
      pulse[i] = 1'b0;
    end
  end

  // Trigger pins rest low between events.
  assign event_source_one = pulse[0];
  assign event_source_two = pulse[1];
  assign event_source_three = pulse[2];

  // The divider takes the clamped word every clock.
  always @(posedge aclk)
    frac_word <= ramp_value;
endmodule : rss_trig_model

// [test/ramp_segment_sequencer_tb.sv]
`timescale 1ns/10ps
`include "rss_params.svh"
module ramp_segment_sequencer_tb;
  typedef struct {logic [2:0] seg; logic [1:0] word;
    logic [31:0] wd; logic [31:0] rdv;} rss_row_t;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ramp_running;
  logic [`RSS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic event_source_one, event_source_two, event_source_three;
  logic marker_out_zero, marker_out_one, fastlock_enable, slip_reduce_enable;
  logic [`RSS_ACC_W-1:0] ramp_value;
  logic [`RSS_IDX_W-1:0] active_segment;
  logic [2:0] fire;
  int err_count, checks_done, n;
  rss_row_t rows [9] = '{
    '{3'h0, 2'h0, 32'h5, 32'h5}, '{3'h0, 2'h1, 32'h2, 32'h2},
    '{3'h0, 2'h2, 32'h95, 32'h95},
    '{3'h1, 2'h0, 32'hfffffffd, 32'h3ffffffd},
    '{3'h1, 2'h1, 32'h3, 32'h3}, '{3'h1, 2'h2, 32'ha, 32'ha},
    '{3'h7, 2'h0, 32'hffffffff, 32'h3fffffff},
    '{3'h7, 2'h1, 32'h1ffff, 32'hffff},
    '{3'h7, 2'h2, 32'hffffffff, 32'h3ff}};

  rss_sequencer i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .event_source_one(event_source_one),
    .event_source_two(event_source_two),
    .event_source_three(event_source_three),
    .marker_out_zero(marker_out_zero), .marker_out_one(marker_out_one),
    .fastlock_enable(fastlock_enable),
    .slip_reduce_enable(slip_reduce_enable), .ramp_value(ramp_value),
    .active_segment(active_segment), .ramp_running(ramp_running));

  rss_trig_model i_trig (
    .aclk(aclk), .fire(fire), .ramp_value(ramp_value),
    .event_source_one(event_source_one),
    .event_source_two(event_source_two),
    .event_source_three(event_source_three));

  // Free-running clock at 200 MHz.
  always #2.5 aclk = ~aclk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] want,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, want);
        chk(s_axi_rresp, er);
        break;
      end
    end
  endtask : rd

  // Counts settled cycles until the given segment is in use.
  task automatic wait_seg(input logic [2:0] s);
    n = 0;
    while (active_segment !== s)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
  endtask : wait_seg

  task automatic pulse(input int b);
    @(posedge aclk);
    fire[b] <= 1'b1;
    @(posedge aclk);
    fire[b] <= 1'b0;
    repeat (12) @(posedge aclk);
    #1;
  endtask : pulse

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // Hang guard, far beyond the expected run length.
  initial
  begin
    #100000;
    err_count++;
    close_out;
  end

  // Main sequence: reset, table of settings, then hand-written runs.
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_rready = 1'b0;
    s_axi_wstrb = 4'hf;
    fire = 3'h0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RSS_OFS_HIGH_LO, 32'hffffffff, `RSS_RESP_OKAY);
    rd(`RSS_OFS_HIGH_HI, 32'h0, `RSS_RESP_OKAY);
    rd(`RSS_OFS_LOW_LO, 32'h0, `RSS_RESP_OKAY);
    for (int i = 0; i < 8; i++)
      rd({4'h1, 1'b0, 3'(i), 4'h8}, 32'h0, `RSS_RESP_OKAY);
    wr(12'h0fc, 32'h1, `RSS_RESP_SLVERR);
    rd(12'h10c, 32'h0, `RSS_RESP_SLVERR);
    $display("reset and map test done");
    foreach (rows[i])
    begin
      wr({4'h1, 1'b0, rows[i].seg, rows[i].word, 2'h0}, rows[i].wd,
         `RSS_RESP_OKAY);
      rd({4'h1, 1'b0, rows[i].seg, rows[i].word, 2'h0}, rows[i].rdv,
         `RSS_RESP_OKAY);
    end
    $display("settings table test done");
    wr(`RSS_OFS_CTRL, 32'h1, `RSS_RESP_OKAY);
    #1;
    chk(active_segment, 33'h0);
    wait_seg(3'h1);
    chk(n, 33'h3);
    chk(ramp_value, 33'ha);
    chk({marker_out_one, marker_out_zero, fastlock_enable}, 33'h3);
    wait_seg(3'h0);
    chk(n, 33'h7);
    chk(ramp_value, 33'h1);
    chk({marker_out_one, marker_out_zero, fastlock_enable}, 33'h4);
    wait_seg(3'h1);
    chk(ramp_value, 33'ha);
    chk(n, 33'h3);
    wr(`RSS_OFS_CTRL, 32'h0, `RSS_RESP_OKAY);
    @(posedge aclk);
    #1;
    chk({ramp_running, marker_out_one, marker_out_zero}, 33'h0);
    $display("chained run test done");
    for (int k = 1; k < 4; k++)
    begin
      wr(12'h108, 32'h110 | (k << 5), `RSS_RESP_OKAY);
      wr(`RSS_OFS_CTRL, 32'h1, `RSS_RESP_OKAY);
      pulse(k % 3);
      chk(active_segment, 33'h0);
      chk(ramp_value, 33'ha);
      pulse(k - 1);
      chk(active_segment, 33'h2);
      wr(`RSS_OFS_CTRL, 32'h0, `RSS_RESP_OKAY);
    end
    $display("event advance test done");
    wr(12'h108, 32'h90, `RSS_RESP_OKAY);
    wr(12'h104, 32'h4, `RSS_RESP_OKAY);
    wr(`RSS_OFS_HIGH_LO, 32'hc, `RSS_RESP_OKAY);
    wr(`RSS_OFS_HIGH_HI, 32'h0, `RSS_RESP_OKAY);
    wr(`RSS_OFS_LOW_LO, 32'h5, `RSS_RESP_OKAY);
    wr(`RSS_OFS_CTRL, 32'h1, `RSS_RESP_OKAY);
    wait_seg(3'h1);
    chk(ramp_value, 33'hc);
    wait_seg(3'h0);
    chk(ramp_value, 33'h5);
    chk({marker_out_one, marker_out_zero}, 33'h2);
    $display("clamp test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({ramp_running, ramp_value} != 34'h0, 33'h0);
    rd(12'h100, 32'h0, `RSS_RESP_OKAY);
    rd(`RSS_OFS_HIGH_LO, 32'hffffffff, `RSS_RESP_OKAY);
    $display("mid-run reset test done");
    close_out;
  end
endmodule : ramp_segment_sequencer_tb
